// ---- rtl/kss_pkg.sv ----
// Shared constants for the keyboard start-stop sender.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
`default_nettype none

package kss_pkg;

  // ==========================================================
  // Register offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] KEY_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RXCHAR_OFS = 8'h0C;

  // ==========================================================
  // Control register fields.
  localparam int SPEED_LSB = 0;
  localparam int BREAK_BIT = 2;
  localparam int LOCK_BIT = 4;
  localparam int UNLOCK_BIT = 5;
  localparam int LCR_BIT = 6;
  localparam int LLF_BIT = 7;
  localparam logic [1:0] SPEED_RST = 2'h0;

  // Status register fields.
  localparam int BUSY_BIT = 0;
  localparam int LOCKED_BIT = 1;
  localparam int EOL_BIT = 2;
  localparam int PEND_BIT = 3;
  localparam int COL_LSB = 8;

  // ==========================================================
  // Character codes and frame layout.
  localparam int CODE_W = 5;
  localparam logic [4:0] BLANK_CODE = 5'h00;
  localparam logic [4:0] CR_CODE_DEF = 5'h08;
  localparam int ELEMS = 7;
  localparam logic [2:0] STOP_ELEM = 3'h6;
  localparam logic [2:0] CLEAR_ELEM = 3'h3;
  localparam logic [1:0] BLANKS_TO_LOCK = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ==========================================================
  // Timing: character rates and element length in clock cycles.
  localparam longint CLK_HZ = 64'd100_000_000;
  localparam longint SEC_PER_MIN = 64'd60;
  localparam longint CPM_SLOW = 64'd368;
  localparam longint CPM_MID = 64'd460;
  localparam longint CPM_FAST = 64'd600;
  localparam longint ELEM_CYC_SLOW = (CLK_HZ * SEC_PER_MIN) / (CPM_SLOW * ELEMS);
  localparam longint ELEM_CYC_MID = (CLK_HZ * SEC_PER_MIN) / (CPM_MID * ELEMS);
  localparam longint ELEM_CYC_FAST = (CLK_HZ * SEC_PER_MIN) / (CPM_FAST * ELEMS);
  localparam int FIFO_DEPTH = 16;
  localparam int EOL_COL_DEF = 64;

endpackage : kss_pkg

`default_nettype wire

// ---- rtl/kss_sender.sv ----
// Keyboard start-stop character sender with AXI4-Lite registers and key FIFO.
// Assumes one 100 MHz clock, synchronous active-low reset and a line driver outside.
// ==========================================================
// Overview of operation
// - Once tripped, a character cycle always runs its full revolution.
// - The held code is copied to the transmit latch at cycle start.
// - Every frame opens with a spacing start element.
// - Data elements follow in code positions 1, 2, 3, 4, 5.
// - A data element is marking for a set bit, spacing otherwise.
// - The last element is a marking stop element.
// - Latch locks mid start element, releases mid stop element.
// - The code register clears a quarter into element 3.
// - A second key loads after that clear; a third waits for the same clear in the next cycle.
// - Local carriage return pulses the local printer only, never the line.
// - Local line feed pulses the local printer only, never the line.
// - Line break holds the line spacing until released.
// - The lockout key locks; locked keys start no cycle nor signal.
// - Two consecutive received blanks lock the keyboard remotely.
// - The release key unlocks the keyboard.
// - The end-of-line lamp lights as the line end nears.
// - Carriage return resets the column and darkens the lamp.
// - Character rate selects 368, 460 or 600 per minute.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`default_nettype none

// ==========================================================
// Key FIFO.
module kss_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } kss_fifo_s;
  kss_fifo_s q;
  kss_fifo_s next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      next_q.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    end
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule : kss_fifo

// ==========================================================
// Sender top.
module kss_sender #(
  parameter int unsigned ELEM_SLOW = int'(kss_pkg::ELEM_CYC_SLOW),
  parameter int unsigned ELEM_MID = int'(kss_pkg::ELEM_CYC_MID),
  parameter int unsigned ELEM_FAST = int'(kss_pkg::ELEM_CYC_FAST),
  parameter int DEPTH = kss_pkg::FIFO_DEPTH,
  parameter int EOL_COL = kss_pkg::EOL_COL_DEF,
  parameter logic [4:0] CR_CODE = kss_pkg::CR_CODE_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic line_mark,
  output logic local_cr_pulse,
  output logic local_lf_pulse,
  output logic eol_lamp
);
  typedef enum logic {KSS_IDLE, KSS_RUN} kss_state_e;
  typedef struct packed {
    kss_state_e st;
    logic [2:0] elem;
    logic [31:0] sub;
    logic [31:0] elem_len;
    logic [4:0] tx_latch;
    logic latch_locked;
    logic [4:0] code;
    logic code_full;
    logic locked;
    logic [1:0] blanks;
    logic [7:0] col;
    logic eol;
    logic mark;
    logic cr_p;
    logic lf_p;
    logic [1:0] speed;
    logic brk;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic push;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } kss_state_s;

  kss_state_s q;
  kss_state_s next_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [4:0] fifo_out_data;
  logic fifo_pop;

  // ==========================================================
  // Key buffer between the register bus and the code register.
  assign fifo_pop = !q.code_full;

  kss_fifo #(
    .WIDTH(kss_pkg::CODE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.wdata[4:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign line_mark = q.mark;
  assign local_cr_pulse = q.cr_p;
  assign local_lf_pulse = q.lf_p;
  assign eol_lamp = q.eol;

  // ==========================================================
  // Next-state logic.
  always_comb begin
    logic wr_go;
    logic cr_now;
    logic lock_set;
    logic [4:0] sent;
    logic [7:0] wa;
    wr_go = 1'b0;
    cr_now = 1'b0;
    lock_set = 1'b0;
    sent = q.tx_latch;
    wa = q.awaddr;
    next_q = q;
    next_q.cr_p = 1'b0;
    next_q.lf_p = 1'b0;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = s_axi_awaddr;
      wa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata;
    end
    if (q.aw_got && q.w_got && !q.push && !q.bvalid) begin
      wr_go = 1'b1;
    end
    if (q.push && fifo_in_ready) begin
      next_q.push = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = kss_pkg::AXI_OKAY;
    end
    if (wr_go) begin
      next_q.bresp = kss_pkg::AXI_OKAY;
      case (wa)
        kss_pkg::CTRL_OFS: begin
          next_q.speed = q.wdata[kss_pkg::SPEED_LSB +: 2];
          next_q.brk = q.wdata[kss_pkg::BREAK_BIT];
          next_q.cr_p = q.wdata[kss_pkg::LCR_BIT];
          next_q.lf_p = q.wdata[kss_pkg::LLF_BIT];
          cr_now = q.wdata[kss_pkg::LCR_BIT];
          if (q.wdata[kss_pkg::UNLOCK_BIT]) begin
            next_q.locked = 1'b0;
            next_q.blanks = 2'h0;
          end
          if (q.wdata[kss_pkg::LOCK_BIT]) begin
            next_q.locked = 1'b1;
          end
          next_q.bvalid = 1'b1;
        end
        kss_pkg::KEY_OFS: begin
          if (q.locked) begin
            next_q.bvalid = 1'b1;
            next_q.bresp = kss_pkg::AXI_SLVERR;
          end else begin
            next_q.push = 1'b1;
          end
        end
        kss_pkg::RXCHAR_OFS: begin
          if (q.wdata[4:0] == kss_pkg::BLANK_CODE) begin
            next_q.blanks = (q.blanks == kss_pkg::BLANKS_TO_LOCK) ? q.blanks : q.blanks + 2'h1;
            if (q.blanks == kss_pkg::BLANKS_TO_LOCK - 2'h1) begin
              lock_set = 1'b1;
            end
          end else begin
            next_q.blanks = 2'h0;
          end
          if (q.wdata[4:0] == CR_CODE) begin
            cr_now = 1'b1;
          end
          next_q.bvalid = 1'b1;
        end
        kss_pkg::STATUS_OFS: begin
          next_q.bvalid = 1'b1;
        end
        default: begin
          next_q.bvalid = 1'b1;
          next_q.bresp = kss_pkg::AXI_SLVERR;
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
    end

    // Register reads answer one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = kss_pkg::AXI_OKAY;
      next_q.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        kss_pkg::CTRL_OFS: begin
          next_q.rdata[kss_pkg::SPEED_LSB +: 2] = q.speed;
          next_q.rdata[kss_pkg::BREAK_BIT] = q.brk;
        end
        kss_pkg::STATUS_OFS: begin
          next_q.rdata[kss_pkg::BUSY_BIT] = (q.st == KSS_RUN);
          next_q.rdata[kss_pkg::LOCKED_BIT] = q.locked;
          next_q.rdata[kss_pkg::EOL_BIT] = q.eol;
          next_q.rdata[kss_pkg::PEND_BIT] = q.code_full;
          next_q.rdata[kss_pkg::COL_LSB +: 8] = q.col;
        end
        kss_pkg::KEY_OFS, kss_pkg::RXCHAR_OFS: begin
          next_q.rdata[4:0] = q.code;
        end
        default: begin
          next_q.rresp = kss_pkg::AXI_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // Code register takes the next key when it is free.
    if (fifo_pop && fifo_out_valid) begin
      next_q.code = fifo_out_data;
      next_q.code_full = 1'b1;
    end

    // Character cycle.
    case (q.st)
      KSS_IDLE: begin
        next_q.elem = 3'h0;
        next_q.sub = 32'h0000_0000;
        if (q.code_full && !q.locked) begin
          next_q.st = KSS_RUN;
          next_q.tx_latch = q.code;
          case (q.speed)
            2'h1: next_q.elem_len = ELEM_MID;
            2'h2: next_q.elem_len = ELEM_FAST;
            default: next_q.elem_len = ELEM_SLOW;
          endcase
        end
      end
      KSS_RUN: begin
        if (q.sub == q.elem_len - 32'h1) begin
          next_q.sub = 32'h0000_0000;
          if (q.elem == kss_pkg::STOP_ELEM) begin
            next_q.st = KSS_IDLE;
            if (sent == CR_CODE) begin
              cr_now = 1'b1;
            end else begin
              next_q.col = (q.col == 8'hFF) ? q.col : q.col + 8'h01;
            end
          end else begin
            next_q.elem = q.elem + 3'h1;
          end
        end else begin
          next_q.sub = q.sub + 32'h1;
        end
        if (q.elem == 3'h0 && q.sub == (q.elem_len >> 1)) begin
          next_q.latch_locked = 1'b1;
        end
        if (q.elem == kss_pkg::STOP_ELEM && q.sub == (q.elem_len >> 1)) begin
          next_q.latch_locked = 1'b0;
        end
        if (q.elem == kss_pkg::CLEAR_ELEM && q.sub == (q.elem_len >> 2) && q.code_full) begin
          next_q.code_full = 1'b0;
        end
      end
      default: begin
        next_q.st = KSS_IDLE;
      end
    endcase

    // Line level: start space, data bits, stop mark, idle mark, break space.
    if (next_q.st == KSS_RUN) begin
      case (next_q.elem)
        3'h0: next_q.mark = 1'b0;
        kss_pkg::STOP_ELEM: next_q.mark = 1'b1;
        default: next_q.mark = next_q.tx_latch[next_q.elem - 3'h1];
      endcase
    end else begin
      next_q.mark = 1'b1;
    end
    if (next_q.brk) begin
      next_q.mark = 1'b0;
    end

    if (lock_set) begin
      next_q.locked = 1'b1;
    end
    if (cr_now) begin
      next_q.col = 8'h00;
    end
    next_q.eol = (next_q.col >= 8'(EOL_COL));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= KSS_IDLE;
      q.mark <= 1'b1;
      q.speed <= kss_pkg::SPEED_RST;
      q.elem_len <= 32'h1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  start_space_a: assert property ((q.st == KSS_IDLE) ##1 (q.st == KSS_RUN) |-> !line_mark)
    else $error("start element not spacing");
  stop_mark_a: assert property ((q.st == KSS_RUN && q.elem == kss_pkg::STOP_ELEM && !q.brk) |-> line_mark)
    else $error("stop element not marking");
  data_bit_a: assert property ((q.st == KSS_RUN && q.elem == 3'h2 && !q.brk) |-> line_mark == q.tx_latch[1])
    else $error("data element does not follow latch");
  latch_hold_a: assert property ((q.st == KSS_RUN) |=> $stable(q.tx_latch) || q.st == KSS_IDLE)
    else $error("transmit latch changed mid cycle");
  no_abort_a: assert property ((q.st == KSS_RUN && q.elem != kss_pkg::STOP_ELEM) |=> q.st == KSS_RUN)
    else $error("cycle ended before stop element");
  break_space_a: assert property (q.brk |-> !line_mark)
    else $error("line marking during break");
  locked_idle_a: assert property ((q.locked && q.st == KSS_IDLE) |=> q.st == KSS_IDLE)
    else $error("locked keyboard started a cycle");
  idle_mark_a: assert property ((q.st == KSS_IDLE && !q.brk) |-> line_mark)
    else $error("idle line not marking");
  eol_track_a: assert property (eol_lamp == (q.col >= 8'(EOL_COL)))
    else $error("end-of-line lamp wrong");
  cr_reset_a: assert property (local_cr_pulse |-> (q.col == 8'h00) && !eol_lamp)
    else $error("carriage return left column set");
  latch_lock_a: assert property ((q.st == KSS_RUN && q.elem inside {[3'h1 : 3'h5]}) |-> q.latch_locked)
    else $error("latch not locked in data elements");
endmodule : kss_sender

`default_nettype wire

// ---- tb/keyboard_start_stop_sender_tb.sv ----
// Self-checking bench for the keyboard start-stop sender.
// Assumes the sender package and the far-end receiver model are compiled first.
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module keyboard_start_stop_sender_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  int lens[3] = '{16, 12, 8};
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr, cur_len;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rs;
  logic line_mark, cr_p, lf_p, eol, rx_valid, rx_err;
  logic [4:0] rx_code;
  logic [4:0] got_q[$];
  int mismatches, cmp_count, cyc, err_cnt, cr_cnt, lf_cnt, low_cnt;

  kss_sender #(.ELEM_SLOW(16), .ELEM_MID(12), .ELEM_FAST(8), .EOL_COL(3)) u_kss_sender (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_mark(line_mark),
    .local_cr_pulse(cr_p), .local_lf_pulse(lf_p), .eol_lamp(eol));
  kss_line_rx u_kss_line_rx (.aclk(aclk), .aresetn(aresetn), .line_mark(line_mark),
    .elem_len(cur_len), .rx_valid(rx_valid), .rx_code(rx_code), .rx_err(rx_err));

  // ==========================================================
  // Clock, monitors and timeout.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    cyc++;
    cr_cnt += int'(cr_p === 1'b1);
    lf_cnt += int'(lf_p === 1'b1);
    low_cnt += int'(line_mark !== 1'b1);
    if (rx_valid === 1'b1) begin
      got_q.push_back(rx_code);
      err_cnt += int'(rx_err !== 1'b0);
    end
    if (cyc == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Bus tasks.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  function automatic logic [31:0] ctl(input int b);
    return 32'h2 | (32'h1 << b);
  endfunction : ctl

  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && got_q.size() < n; i++) @(posedge aclk);
  endtask : wait_q

  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    `CHK("idle line", 1'b1, line_mark)
    rd(kss_pkg::CTRL_OFS);
    `CHK("ctrl reset", {kss_pkg::AXI_OKAY, 32'h0}, {rs, rdv})
    rd(kss_pkg::STATUS_OFS);
    `CHK("status reset", 32'h0, rdv)
    rd(8'h10);
    `CHK("unmapped read", {kss_pkg::AXI_SLVERR, 32'h0}, {rs, rdv})
    wr(8'h10, 32'h1);
    `CHK("unmapped write", kss_pkg::AXI_SLVERR, rs)
  endtask : t_reset

  task automatic t_speeds();
    int n;
    for (int s = 0; s < 3; s++) begin
      wr(kss_pkg::CTRL_OFS, 32'(s));
      rd(kss_pkg::CTRL_OFS);
      `CHK("speed", 32'(s), rdv)
      cur_len <= 8'(lens[s]);
      got_q.delete();
      wr(kss_pkg::KEY_OFS, 32'h15);
      `CHK("key okay", kss_pkg::AXI_OKAY, rs)
      for (int i = 0; i < 500 && line_mark === 1'b1; i++) @(posedge aclk);
      n = 0;
      while (line_mark === 1'b0 && n < 100) begin @(posedge aclk); n++; end
      `CHK("start length", lens[s], n)
      wait_q(1);
      `CHK("code", 5'h15, got_q[0])
    end
  endtask : t_speeds

  task automatic t_back();
    int t;
    got_q.delete();
    err_cnt = 0;
    wr(kss_pkg::KEY_OFS, 32'h01);
    wr(kss_pkg::KEY_OFS, 32'h1E);
    wr(kss_pkg::KEY_OFS, 32'h0A);
    t = cyc;
    rd(kss_pkg::STATUS_OFS);
    `CHK("busy pending", 2'b11, {rdv[kss_pkg::BUSY_BIT], rdv[kss_pkg::PEND_BIT]})
    wait_q(3);
    `CHK("back to back", 1'b1, (cyc - t) <= 21 * 8)
    `CHK("order", {5'h01, 5'h1E, 5'h0A}, {got_q[0], got_q[1], got_q[2]})
    `CHK("frame errors", 0, err_cnt)
  endtask : t_back

  task automatic t_fifo();
    int t, mx;
    got_q.delete();
    mx = 0;
    for (int i = 0; i < 20; i++) begin
      t = cyc;
      wr(kss_pkg::KEY_OFS, 32'(i + 16));
      if (cyc - t > mx) mx = cyc - t;
    end
    `CHK("fifo backpressure", 1'b1, mx > 8)
    wait_q(20);
    for (int i = 0; i < 20; i++) `CHK("fifo order", 5'(i + 16), got_q[i])
  endtask : t_fifo

  task automatic t_lock();
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::LOCK_BIT));
    rd(kss_pkg::STATUS_OFS);
    `CHK("locked", 1'b1, rdv[kss_pkg::LOCKED_BIT])
    low_cnt = 0;
    wr(kss_pkg::KEY_OFS, 32'h03);
    `CHK("locked key", kss_pkg::AXI_SLVERR, rs)
    repeat (80) @(posedge aclk);
    `CHK("locked line", 0, low_cnt)
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::UNLOCK_BIT));
    got_q.delete();
    wr(kss_pkg::KEY_OFS, 32'h03);
    wait_q(1);
    `CHK("unlocked send", 1, got_q.size())
    rd(kss_pkg::KEY_OFS);
    `CHK("code reg", 32'h3, rdv)
    wr(kss_pkg::RXCHAR_OFS, 32'h0);
    wr(kss_pkg::RXCHAR_OFS, 32'h1);
    wr(kss_pkg::RXCHAR_OFS, 32'h0);
    rd(kss_pkg::STATUS_OFS);
    `CHK("split blanks", 1'b0, rdv[kss_pkg::LOCKED_BIT])
    wr(kss_pkg::RXCHAR_OFS, 32'h0);
    rd(kss_pkg::STATUS_OFS);
    `CHK("remote lock", 1'b1, rdv[kss_pkg::LOCKED_BIT])
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::UNLOCK_BIT));
    rd(kss_pkg::STATUS_OFS);
    `CHK("release", 1'b0, rdv[kss_pkg::LOCKED_BIT])
  endtask : t_lock

  task automatic t_break_local();
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::BREAK_BIT));
    repeat (2) @(posedge aclk);
    low_cnt = 0;
    repeat (40) @(posedge aclk);
    `CHK("break held", 40, low_cnt)
    wr(kss_pkg::CTRL_OFS, 32'h2);
    repeat (2) @(posedge aclk);
    `CHK("break release", 1'b1, line_mark)
    repeat (80) @(posedge aclk);
    {cr_cnt, lf_cnt, low_cnt} = '0;
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::LCR_BIT));
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::LLF_BIT));
    repeat (4) @(posedge aclk);
    `CHK("local cr", 1, cr_cnt)
    `CHK("local lf", 1, lf_cnt)
    `CHK("line quiet", 0, low_cnt)
  endtask : t_break_local

  task automatic t_eol();
    got_q.delete();
    wr(kss_pkg::KEY_OFS, 32'h11);
    wr(kss_pkg::KEY_OFS, 32'h12);
    wait_q(2);
    repeat (8) @(posedge aclk);
    `CHK("eol below", 1'b0, eol)
    wr(kss_pkg::KEY_OFS, 32'h13);
    wait_q(3);
    repeat (8) @(posedge aclk);
    `CHK("eol lit", 1'b1, eol)
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::LCR_BIT));
    repeat (2) @(posedge aclk);
    `CHK("eol dark", 1'b0, eol)
    rd(kss_pkg::STATUS_OFS);
    `CHK("column", 8'h0, rdv[15:8])
    got_q.delete();
    wr(kss_pkg::KEY_OFS, 32'h11);
    wr(kss_pkg::KEY_OFS, 32'(kss_pkg::CR_CODE_DEF));
    wait_q(2);
    repeat (8) @(posedge aclk);
    rd(kss_pkg::STATUS_OFS);
    `CHK("sent cr column", 8'h0, rdv[15:8])
    wr(kss_pkg::KEY_OFS, 32'h11);
    wait_q(3);
    repeat (8) @(posedge aclk);
    wr(kss_pkg::RXCHAR_OFS, 32'(kss_pkg::CR_CODE_DEF));
    rd(kss_pkg::STATUS_OFS);
    `CHK("rx cr column", 8'h0, rdv[15:8])
  endtask : t_eol

  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    cur_len = 8'd16;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_speeds();
    t_back();
    t_fifo();
    t_lock();
    t_break_local();
    wr(kss_pkg::CTRL_OFS, ctl(kss_pkg::LCR_BIT));
    t_eol();
    report_and_stop();
  end
endmodule : keyboard_start_stop_sender_tb

`default_nettype wire

// ---- tb/kss_line_rx.sv ----
// Far-end receiving station that decodes start-stop frames seen on the signal line.
// Assumes the bench supplies the element length in clock cycles for the current rate.
`default_nettype none

module kss_line_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_mark,
  input wire logic [7:0] elem_len,
  output logic rx_valid,
  output logic [4:0] rx_code,
  output logic rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic start_bad;
  logic [4:0] sh;
  int cnt;
  int h;

  // ==========================================================
  // Frame decoder sampling each element at its middle.
  always_comb h = int'(elem_len) / 2;

  always_ff @(posedge aclk) begin
    rx_valid <= 1'b0;
    if (!aresetn) begin
      busy <= 1'b0;
      rx_code <= 5'h00;
      rx_err <= 1'b0;
    end else if (!busy) begin
      busy <= !line_mark;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
      if (cnt == h) begin
        start_bad <= line_mark;
      end
      for (int k = 1; k <= 5; k++) begin
        if (cnt == k * int'(elem_len) + h) begin
          sh[k - 1] <= line_mark;
        end
      end
      if (cnt == 6 * int'(elem_len) + h) begin
        rx_valid <= 1'b1;
        rx_code <= sh;
        rx_err <= start_bad || !line_mark;
        busy <= 1'b0;
      end
    end
  end
endmodule : kss_line_rx

`default_nettype wire
